// >>> verilog/svdc_ctrl.sv
// Supply monitor control: boot config, control/status and level-select registers
`timescale 1ns/1ns
`include "svdc_defs.svh"

module svdc_ctrl
   import svdc_pkg::*;
#(
   parameter int SETTLE_TIME_NS = `SVDC_SETTLE_TIME_NS,
   parameter int CNT_W = 12
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic otherResetReq,
   input wire logic [7:0] bootConfig,
   input wire logic cmpBelowHigh,
   input wire logic cmpBelowLow,
   input wire logic [19:0] busAddr,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [7:0] busWrData,
   input wire logic [7:0] busWrMask,
   output logic [7:0] busRdData,
   output logic detectorEnable,
   output logic [2:0] baseLevel,
   output logic [1:0] subLevel,
   output logic compareLow,
   output logic supplyDropInterrupt,
   output logic detectorReset
);

   // Least time rounds up, never below one cycle
   localparam int SETTLE_RAW = (SETTLE_TIME_NS + `SVDC_CLK_PERIOD_NS - 1) / `SVDC_CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
   localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES);
   localparam logic [7:0] LS_RST_RESET = `SVDC_LS_RESET_RESET;
   localparam logic [7:0] LS_RST_INTERRUPT = `SVDC_LS_RESET_INTERRUPT;
   localparam logic [7:0] LS_RST_INT_RESET = `SVDC_LS_RESET_INT_RESET;

   logic fullRst;
   logic [7:0] bootCfg_q;
   svdc_mode_t mode;
   logic [1:0] bootMode;
   logic [2:0] bootBase;
   logic [1:0] bootSub;
   logic cfgValid;
   logic intResetMode;
   logic detectorOn;

   logic belowHighS;
   logic belowLowS;
   logic belowHighPrev_q;
   logic belowLowPrev_q;
   logic selBelow;
   logic flag;

   logic writeEnable_q;
   logic modeBit_q;
   logic modeBit_d;
   logic levelBit_q;
   logic levelBit_d;
   logic [CNT_W-1:0] settleCnt_q;
   logic settleBusy;
   logic maskActive;

   logic csHit;
   logic lsHit;
   logic cfgHit;
   logic csWrite;
   logic lsWrite;
   logic [7:0] csCur;
   logic [7:0] lsCur;
   logic [7:0] csMerged;
   logic [7:0] lsMerged;

   svdc_rst_state_t rstState_q;
   svdc_rst_state_t rstState_d;
   logic detectorReset_q;
   logic inDetReset;
   logic releaseCond;
   logic irqEvent;
   logic supplyDropInterrupt_q;

   logic [7:0] busRdData_q;
   logic detectorEnable_q;
   logic [2:0] baseLevel_q;
   logic [1:0] subLevel_q;
   logic compareLow_q;

   // Power-on and every other non-detector source act as the full reset
   assign fullRst = !rst_n || otherResetReq;

   // Boot byte caught while a full reset is held, stable afterwards
   always_ff @(posedge sys_clk) begin
      if (fullRst) begin
         bootCfg_q <= bootConfig;
      end
   end

   assign bootMode = bootCfg_q[`SVDC_CFG_MODE_HI:`SVDC_CFG_MODE_LO];
   assign bootBase = bootCfg_q[`SVDC_CFG_BASE_HI:`SVDC_CFG_BASE_LO];
   assign bootSub = bootCfg_q[`SVDC_CFG_SUB_HI:`SVDC_CFG_SUB_LO];

   // Prohibited codes leave the detector off rather than guessing a level
   always_comb begin
      cfgValid = (bootBase != `SVDC_BASE_NONE);
      if (bootMode == `SVDC_BOOT_MODE_INT_RESET) begin
         cfgValid = cfgValid && (bootBase <= `SVDC_BASE_MAX_INT_RESET) &&
                    (bootSub != `SVDC_SUB_PROHIBITED);
      end
   end

   always_comb begin
      mode = SVDC_MODE_OFF;
      if (cfgValid) begin
         case (bootMode)
            `SVDC_BOOT_MODE_INT_RESET: mode = SVDC_MODE_INT_RESET;
            `SVDC_BOOT_MODE_RESET: mode = SVDC_MODE_RESET;
            `SVDC_BOOT_MODE_INTERRUPT: mode = SVDC_MODE_INTERRUPT;
            default: mode = SVDC_MODE_OFF;
         endcase
      end
   end

   assign intResetMode = (mode == SVDC_MODE_INT_RESET);
   assign detectorOn = (mode != SVDC_MODE_OFF);

   svdc_sync #(
      .WIDTH(2),
      .RESET_VAL(1'b1)
   ) uSync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .din({cmpBelowHigh, cmpBelowLow}),
      .dout({belowHighS, belowLowS})
   );

   always_ff @(posedge sys_clk) begin
      if (fullRst) begin
         belowHighPrev_q <= 1'b1;
         belowLowPrev_q <= 1'b1;
      end else begin
         belowHighPrev_q <= belowHighS;
         belowLowPrev_q <= belowLowS;
      end
   end

   // Level bit 0 watches the high level, 1 the low or single level
   assign selBelow = levelBit_q ? belowLowS : belowHighS;
   assign flag = detectorOn && selBelow;

   assign settleBusy = (settleCnt_q != '0);
   // Mask only exists in interrupt-and-reset mode
   assign maskActive = intResetMode && (writeEnable_q || settleBusy);

   assign cfgHit = (busAddr == `SVDC_ADDR_BOOT_CFG);
   assign csHit = (busAddr == `SVDC_ADDR_CTRL_STATUS);
   assign lsHit = (busAddr == `SVDC_ADDR_LEVEL_SELECT);

   assign inDetReset = (rstState_q == SVDC_RST_ACTIVE);

   always_comb begin
      csCur = `SVDC_CS_RESET;
      csCur[`SVDC_CS_WE_BIT] = writeEnable_q;
      csCur[`SVDC_CS_MASK_BIT] = maskActive;
      csCur[`SVDC_CS_FLAG_BIT] = flag;
      lsCur = 8'h00;
      lsCur[`SVDC_LS_MODE_BIT] = modeBit_q;
      lsCur[`SVDC_LS_LEVEL_BIT] = levelBit_q;
   end

   // Byte lane mask lets single-bit instructions touch one bit only
   assign csMerged = (csCur & ~busWrMask) | (busWrData & busWrMask);
   assign lsMerged = (lsCur & ~busWrMask) | (busWrData & busWrMask);

   assign csWrite = busWrite && csHit && !inDetReset;
   // Software is expected to open the gate first; otherwise the write is dropped
   assign lsWrite = busWrite && lsHit && !inDetReset && intResetMode &&
                    writeEnable_q;

   // Only the enable bit is stored; flag and mask are computed and ignore writes
   always_ff @(posedge sys_clk) begin
      if (fullRst) begin
         writeEnable_q <= 1'b0;
      end else if (csWrite) begin
         writeEnable_q <= csMerged[`SVDC_CS_WE_BIT];
      end
   end

   always_comb begin
      modeBit_d = modeBit_q;
      levelBit_d = levelBit_q;
      if (inDetReset) begin
         modeBit_d = modeBit_q;
         levelBit_d = levelBit_q;
      end else if (intResetMode && irqEvent) begin
         // After the warning, arm the low level for reset
         modeBit_d = 1'b1;
         levelBit_d = 1'b1;
      end else if (lsWrite) begin
         modeBit_d = lsMerged[`SVDC_LS_MODE_BIT];
         levelBit_d = lsMerged[`SVDC_LS_LEVEL_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (fullRst) begin
         case (bootConfig[`SVDC_CFG_MODE_HI:`SVDC_CFG_MODE_LO])
            `SVDC_BOOT_MODE_RESET: begin
               modeBit_q <= LS_RST_RESET[`SVDC_LS_MODE_BIT];
               levelBit_q <= LS_RST_RESET[`SVDC_LS_LEVEL_BIT];
            end
            `SVDC_BOOT_MODE_INTERRUPT: begin
               modeBit_q <= LS_RST_INTERRUPT[`SVDC_LS_MODE_BIT];
               levelBit_q <= LS_RST_INTERRUPT[`SVDC_LS_LEVEL_BIT];
            end
            default: begin
               modeBit_q <= LS_RST_INT_RESET[`SVDC_LS_MODE_BIT];
               levelBit_q <= LS_RST_INT_RESET[`SVDC_LS_LEVEL_BIT];
            end
         endcase
      end else begin
         modeBit_q <= modeBit_d;
         levelBit_q <= levelBit_d;
      end
   end

   // Reference needs time after a switch; hide its output meanwhile
   always_ff @(posedge sys_clk) begin
      if (fullRst || inDetReset) begin
         settleCnt_q <= '0;
      end else if (intResetMode && (irqEvent || (levelBit_d != levelBit_q))) begin
         settleCnt_q <= SETTLE_LOAD;
      end else if (settleBusy) begin
         settleCnt_q <= settleCnt_q - 1'b1;
      end
   end

   // Release compares the high level in interrupt-and-reset, the single one in reset and interrupt modes; off releases at once
   always_comb begin
      case (mode)
         SVDC_MODE_INT_RESET: releaseCond = !belowHighS;
         SVDC_MODE_RESET: releaseCond = !belowLowS;
         SVDC_MODE_INTERRUPT: releaseCond = !belowLowS;
         default: releaseCond = 1'b1;
      endcase
   end

   always_comb begin
      rstState_d = rstState_q;
      case (rstState_q)
         SVDC_RST_POWERON: begin
            if (releaseCond) begin
               rstState_d = SVDC_RST_IDLE;
            end
         end
         SVDC_RST_IDLE: begin
            if (intResetMode && belowLowS && !maskActive) begin
               rstState_d = SVDC_RST_ACTIVE;
            end else if (mode == SVDC_MODE_RESET && belowLowS) begin
               rstState_d = SVDC_RST_ACTIVE;
            end
         end
         SVDC_RST_ACTIVE: begin
            if (releaseCond) begin
               rstState_d = SVDC_RST_IDLE;
            end
         end
         default: rstState_d = SVDC_RST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (fullRst) begin
         rstState_q <= SVDC_RST_POWERON;
      end else begin
         rstState_q <= rstState_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (fullRst) begin
         detectorReset_q <= 1'b1;
      end else begin
         detectorReset_q <= (rstState_d != SVDC_RST_IDLE);
      end
   end

   // Warnings are only raised while the device is running
   always_comb begin
      irqEvent = 1'b0;
      if (rstState_q == SVDC_RST_IDLE) begin
         case (mode)
            SVDC_MODE_INT_RESET: begin
               irqEvent = belowHighS && !belowHighPrev_q && !maskActive;
            end
            SVDC_MODE_INTERRUPT: begin
               irqEvent = (belowLowS != belowLowPrev_q);
            end
            default: irqEvent = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (fullRst) begin
         supplyDropInterrupt_q <= 1'b0;
      end else begin
         supplyDropInterrupt_q <= irqEvent;
      end
   end

   // Read data answers one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (fullRst) begin
         busRdData_q <= `SVDC_RD_UNMAPPED;
      end else if (busRead) begin
         if (csHit) begin
            busRdData_q <= csCur;
         end else if (lsHit) begin
            busRdData_q <= lsCur;
         end else if (cfgHit) begin
            busRdData_q <= bootCfg_q;
         end else begin
            busRdData_q <= `SVDC_RD_UNMAPPED;
         end
      end
   end

   // Selector settings for the analog comparators
   always_ff @(posedge sys_clk) begin
      if (fullRst) begin
         detectorEnable_q <= 1'b0;
         baseLevel_q <= 3'h0;
         subLevel_q <= 2'h0;
         compareLow_q <= 1'b0;
      end else begin
         detectorEnable_q <= detectorOn;
         baseLevel_q <= bootBase;
         subLevel_q <= bootSub;
         compareLow_q <= levelBit_q;
      end
   end

   assign busRdData = busRdData_q;
   assign detectorEnable = detectorEnable_q;
   assign baseLevel = baseLevel_q;
   assign subLevel = subLevel_q;
   assign compareLow = compareLow_q;
   assign supplyDropInterrupt = supplyDropInterrupt_q;
   assign detectorReset = detectorReset_q;

endmodule

// >>> verilog/svdc_defs.svh
// Register map, field positions, reset values and timing in nanoseconds of the supply monitor
`ifndef SVDC_DEFS_SVH
`define SVDC_DEFS_SVH

`define SVDC_ADDR_BOOT_CFG 20'h000C1
`define SVDC_ADDR_CTRL_STATUS 20'hFFFA9
`define SVDC_ADDR_LEVEL_SELECT 20'hFFFAA

`define SVDC_CS_WE_BIT 7
`define SVDC_CS_MASK_BIT 1
`define SVDC_CS_FLAG_BIT 0
`define SVDC_LS_MODE_BIT 7
`define SVDC_LS_LEVEL_BIT 0

`define SVDC_CFG_BASE_HI 7
`define SVDC_CFG_BASE_LO 5
`define SVDC_CFG_PORT_BIT 4
`define SVDC_CFG_SUB_HI 3
`define SVDC_CFG_SUB_LO 2
`define SVDC_CFG_MODE_HI 1
`define SVDC_CFG_MODE_LO 0

`define SVDC_BOOT_MODE_INT_RESET 2'h2
`define SVDC_BOOT_MODE_RESET 2'h3
`define SVDC_BOOT_MODE_INTERRUPT 2'h1
`define SVDC_SUB_PROHIBITED 2'h3
`define SVDC_BASE_MAX_INT_RESET 3'h3
`define SVDC_BASE_NONE 3'h0

`define SVDC_CS_RESET 8'h00
`define SVDC_LS_RESET_INT_RESET 8'h00
`define SVDC_LS_RESET_RESET 8'h81
`define SVDC_LS_RESET_INTERRUPT 8'h01
`define SVDC_RD_UNMAPPED 8'h00

`define SVDC_CLK_PERIOD_NS 40
`define SVDC_SETTLE_TIME_NS 640

`endif

// >>> verilog/svdc_pkg.sv
// Types shared by the supply monitor control logic
package svdc_pkg;

   typedef enum logic [1:0] {
      SVDC_MODE_OFF,
      SVDC_MODE_INT_RESET,
      SVDC_MODE_RESET,
      SVDC_MODE_INTERRUPT
   } svdc_mode_t;

   typedef enum logic [1:0] {
      SVDC_RST_IDLE,
      SVDC_RST_POWERON,
      SVDC_RST_ACTIVE
   } svdc_rst_state_t;

endpackage

// >>> verilog/svdc_sync.sv
// Two-flop synchroniser for the comparator levels
`timescale 1ns/1ns

module svdc_sync #(
   parameter int WIDTH = 2,
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   genvar i;

   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic stage1_q;
         logic stage2_q;

         // Reset to "below" so nothing is released before real samples arrive
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               stage1_q <= RESET_VAL;
               stage2_q <= RESET_VAL;
            end else begin
               stage1_q <= din[i];
               stage2_q <= stage1_q;
            end
         end

         assign dout[i] = stage2_q;
      end
   endgenerate

endmodule

// >>> dv/svdc_chk.sv
// Port-level assertions for the supply monitor control block
`timescale 1ns/1ns

module svdc_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic otherResetReq,
   input wire logic [7:0] bootConfig,
   input wire logic cmpBelowHigh,
   input wire logic cmpBelowLow,
   input wire logic [19:0] busAddr,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [7:0] busWrData,
   input wire logic [7:0] busWrMask,
   input wire logic [7:0] busRdData,
   input wire logic detectorEnable,
   input wire logic [2:0] baseLevel,
   input wire logic [1:0] subLevel,
   input wire logic compareLow,
   input wire logic supplyDropInterrupt,
   input wire logic detectorReset
);
   logic csRd;
   logic lsRd;
   logic badRd;
   assign csRd = busRead && busAddr == 20'hFFFA9;
   assign lsRd = busRead && busAddr == 20'hFFFAA;
   assign badRd = busRead && !csRd && !lsRd && busAddr != 20'h000C1;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // Four samples cover the two synchroniser flops plus the output register
   sequence s_low_held;
      (cmpBelowLow && detectorEnable && !otherResetReq && bootConfig[1:0] == 2'h3) [*4];
   endsequence
   sequence s_low_clear;
      (!cmpBelowLow && detectorEnable && !otherResetReq && bootConfig[1:0] == 2'h3) [*4];
   endsequence
   sequence s_cross;
      (bootConfig[1:0] == 2'h1 && detectorEnable && !otherResetReq && $changed(cmpBelowLow))
         ##1 $stable(cmpBelowLow) [*2];
   endsequence

   a_unmapped_read: assert property (badRd |=> busRdData == 8'h00)
      else $error("unmapped read not zero");
   a_status_zeros: assert property (csRd |=> busRdData[6:2] == 5'h00)
      else $error("status unused bits not zero");
   a_level_zeros: assert property (lsRd |=> busRdData[6:1] == 6'h00)
      else $error("level select unused bits not zero");
   a_flag_off: assert property (csRd && !detectorEnable |=> !busRdData[0])
      else $error("flag set with detector off");
   a_power_hold: assert property ($rose(rst_n) |-> detectorReset && !supplyDropInterrupt)
      else $error("reset not held at release");
   a_irq_single: assert property (supplyDropInterrupt |=> !supplyDropInterrupt)
      else $error("interrupt longer than one cycle");
   a_irq_level: assert property (supplyDropInterrupt && bootConfig[1:0] == 2'h2 |-> ##[0:1] compareLow)
      else $error("level bit not switched on interrupt");
   a_irq_cause: assert property (supplyDropInterrupt && bootConfig[1:0] == 2'h2 |-> $past(cmpBelowHigh, 2))
      else $error("interrupt without high comparator");
   a_reset_low: assert property (s_low_held |=> detectorReset)
      else $error("no reset below level");
   a_reset_release: assert property (s_low_clear |=> !detectorReset)
      else $error("reset not released");
   a_cross_irq: assert property (s_cross |-> ##[0:2] supplyDropInterrupt)
      else $error("no interrupt on crossing");
endmodule

bind svdc_ctrl svdc_chk svdc_chk_i (.sys_clk, .rst_n, .otherResetReq, .bootConfig,
   .cmpBelowHigh, .cmpBelowLow, .busAddr, .busWrite, .busRead, .busWrData, .busWrMask,
   .busRdData, .detectorEnable, .baseLevel, .subLevel, .compareLow, .supplyDropInterrupt,
   .detectorReset);

// >>> dv/testbench.sv
// Directed register and comparator bench for the supply monitor control block
`timescale 1ns/1ns

module testbench;
   localparam logic [19:0] CS = 20'hFFFA9;
   localparam logic [19:0] LS = 20'hFFFAA;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic otherResetReq = 1'b0;
   logic [7:0] bootConfig = 8'h2A;
   logic cmpBelowHigh = 1'b0;
   logic cmpBelowLow = 1'b0;
   logic [19:0] busAddr = 20'h00000;
   logic busWrite = 1'b0;
   logic busRead = 1'b0;
   logic [7:0] busWrData = 8'h00;
   logic [7:0] busWrMask = 8'h00;
   logic [7:0] busRdData;
   logic detectorEnable, compareLow, supplyDropInterrupt, detectorReset;
   logic [2:0] baseLevel;
   logic [1:0] subLevel;
   int bad_count = 0;
   int total_checks = 0;
   int irqCount = 0;
   logic [7:0] cfgs [3] = '{8'h2A, 8'h2F, 8'h2D};
   logic [7:0] lsExp [3] = '{8'h00, 8'h81, 8'h01};
   logic [7:0] pcfg [3] = '{8'h2E, 8'h8A, 8'h6A};
   logic pen [3] = '{1'b0, 1'b0, 1'b1};

   // Settle wait shortened to four cycles to keep the run brief
   svdc_ctrl #(.SETTLE_TIME_NS(160)) svdc_ctrl_i (.sys_clk, .rst_n, .otherResetReq,
      .bootConfig, .cmpBelowHigh, .cmpBelowLow, .busAddr, .busWrite, .busRead, .busWrData,
      .busWrMask, .busRdData, .detectorEnable, .baseLevel, .subLevel, .compareLow,
      .supplyDropInterrupt, .detectorReset);

   initial begin
      forever #20 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (supplyDropInterrupt === 1'b1) irqCount++;
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [7:0] m);
      @(posedge sys_clk);
      busWrite <= 1'b1;
      busAddr <= a;
      busWrData <= d;
      busWrMask <= m;
      @(posedge sys_clk);
      busWrite <= 1'b0;
   endtask

   task automatic rdc(input logic [19:0] a, input string name, input logic [7:0] exp);
      @(posedge sys_clk);
      busRead <= 1'b1;
      busAddr <= a;
      @(posedge sys_clk);
      busRead <= 1'b0;
      @(negedge sys_clk);
      chk(name, busRdData, exp);
   endtask

   // Bounded wait: a missing event shows as a mismatch, not a hang
   task automatic waitOut(input bit irq, input logic v);
      int n;
      n = 0;
      while ((irq ? supplyDropInterrupt : detectorReset) !== v && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      chk(irq ? "interrupt" : "detectorReset", irq ? supplyDropInterrupt : detectorReset, v);
   endtask

   task automatic boot(input logic [7:0] cfg);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      bootConfig <= cfg;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #400000;
      bad_count++;
      summarize();
   end

   initial begin
      for (int i = 0; i < 3; i++) begin
         boot(cfgs[i]);
         waitOut(1'b0, 1'b0);
         rdc(LS, "level select", lsExp[i]);
         rdc(CS, "status", 8'h00);
         rdc(20'h000C1, "boot byte", cfgs[i]);
      end
      for (int i = 0; i < 3; i++) begin
         boot(pcfg[i]);
         repeat (5) @(posedge sys_clk);
         chk("detectorEnable", detectorEnable, pen[i]);
      end
      chk("baseLevel", baseLevel, 3'h3);
      chk("subLevel", subLevel, 2'h2);
      $display("test boot values done");
      boot(8'h2A);
      waitOut(1'b0, 1'b0);
      irqCount = 0;
      wr(CS, 8'hFF, 8'hFF);
      rdc(CS, "status", 8'h82);
      wr(LS, 8'h01, 8'h01);
      rdc(LS, "level select", 8'h01);
      chk("compareLow", compareLow, 1'b1);
      wr(LS, 8'h00, 8'hFF);
      rdc(LS, "level select", 8'h00);
      wr(CS, 8'h00, 8'h80);
      wr(LS, 8'h01, 8'h01);
      rdc(LS, "level select", 8'h00);
      repeat (8) @(posedge sys_clk);
      rdc(CS, "status", 8'h00);
      wr(CS, 8'h80, 8'h80);
      cmpBelowHigh <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rdc(CS, "status", 8'h83);
      wr(CS, 8'h00, 8'h80);
      rdc(CS, "status", 8'h01);
      chk("irq count", 8'(irqCount), 8'h00);
      cmpBelowHigh <= 1'b0;
      repeat (4) @(posedge sys_clk);
      cmpBelowHigh <= 1'b1;
      waitOut(1'b1, 1'b1);
      rdc(CS, "status", 8'h02);
      repeat (8) @(posedge sys_clk);
      rdc(LS, "level select", 8'h81);
      cmpBelowLow <= 1'b1;
      waitOut(1'b0, 1'b1);
      cmpBelowLow <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("detectorReset", detectorReset, 1'b1);
      cmpBelowHigh <= 1'b0;
      waitOut(1'b0, 1'b0);
      rdc(LS, "level select", 8'h81);
      chk("irq count", 8'(irqCount), 8'h01);
      wr(CS, 8'h80, 8'h80);
      otherResetReq <= 1'b1;
      repeat (2) @(posedge sys_clk);
      otherResetReq <= 1'b0;
      waitOut(1'b0, 1'b0);
      rdc(CS, "status", 8'h00);
      rdc(LS, "level select", 8'h00);
      $display("test interrupt and reset done");
      boot(8'h2F);
      waitOut(1'b0, 1'b0);
      wr(CS, 8'h80, 8'h80);
      rdc(CS, "status", 8'h80);
      wr(LS, 8'h00, 8'hFF);
      rdc(LS, "level select", 8'h81);
      cmpBelowLow <= 1'b1;
      waitOut(1'b0, 1'b1);
      cmpBelowLow <= 1'b0;
      waitOut(1'b0, 1'b0);
      rdc(CS, "status", 8'h80);
      $display("test reset mode done");
      boot(8'h2D);
      waitOut(1'b0, 1'b0);
      cmpBelowLow <= 1'b1;
      waitOut(1'b1, 1'b1);
      rdc(CS, "status", 8'h01);
      cmpBelowLow <= 1'b0;
      waitOut(1'b1, 1'b1);
      chk("detectorReset", detectorReset, 1'b0);
      $display("test interrupt mode done");
      summarize();
   end
endmodule
